// ==== rdc_axil.sv ====
`timescale 1ns/1ps
`include "rdc_map.svh"
module rdc_axil import rdc_pkg::*; (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // write address and data
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // read channels
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // register side
   output logic             wr_en,
   output logic [3:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       rd_addr,
   input  wire logic [31:0] rd_data
);
   logic       aw_full_q;
   logic       w_full_q;
   logic [3:0] wstrb_q;
   logic       rd_pend_q;
   logic       wr_hit;

   // the mode word is read only, so a write to it is refused
   assign wr_hit = (wr_addr == `RDC_OFS_CMD) || (wr_addr == `RDC_OFS_ADDR)
                   || (wr_addr == `RDC_OFS_STAT);

   // ************************************************************
   // write path: address and data in either order, one at a time
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b0;
         wready    <= 1'b0;
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         wstrb_q   <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= `RDC_OKAY;
         wr_en     <= 1'b0;
         wr_addr   <= 4'h0;
         wr_data   <= 32'h0;
      end else begin
         wr_en <= 1'b0;
         if (awvalid && awready) begin
            aw_full_q <= 1'b1;
            awready   <= 1'b0;
            wr_addr   <= awaddr;
         end else if (!aw_full_q && !bvalid) begin
            awready <= 1'b1;
         end
         if (wvalid && wready) begin
            w_full_q <= 1'b1;
            wready   <= 1'b0;
            wr_data  <= wdata;
            wstrb_q  <= wstrb;
         end else if (!w_full_q && !bvalid) begin
            wready <= 1'b1;
         end
         if (aw_full_q && w_full_q && !bvalid) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid    <= 1'b1;
            if (wr_hit && wstrb_q == 4'hf) begin
               wr_en <= 1'b1;
               bresp <= `RDC_OKAY;
            end else begin
               bresp <= `RDC_SLVERR;
            end
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ************************************************************
   // read path
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready   <= 1'b0;
         rvalid    <= 1'b0;
         rdata     <= 32'h0;
         rresp     <= `RDC_OKAY;
         rd_addr   <= 4'h0;
         rd_pend_q <= 1'b0;
      end else begin
         if (arvalid && arready) begin
            arready   <= 1'b0;
            rd_addr   <= araddr;
            rd_pend_q <= 1'b1;
         end else if (!rd_pend_q && !rvalid) begin
            arready <= 1'b1;
         end
         if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            rvalid    <= 1'b1;
            rdata     <= (rd_addr[1:0] == 2'h0) ? rd_data : 32'h0;
            rresp     <= (rd_addr[1:0] == 2'h0) ? `RDC_OKAY : `RDC_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule : rdc_axil

// ==== rdc_ctrl.sv ====
`timescale 1ns/1ps
`include "rdc_map.svh"
module rdc_ctrl import rdc_pkg::*; #(
   parameter int          DIV      = 1,
   parameter int          ORG      = 0,
   parameter logic [3:0]  MSR_CYC  = `RDC_MSR_CYC,
   parameter logic [10:0] LOOP_CYC = `RDC_LOOP_CYC
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // register bus
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // device pins
   output logic             dev_clk,
   output logic             dev_clk_n,
   output logic             chip_select_n,
   output logic             write_enable_n,
   output logic             refresh_strobe_n,
   output logic [20:0]      address,
   output logic [2:0]       bank_select
);
   logic        wr_en;
   logic [3:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  rd_addr;
   logic [31:0] rd_data;
   logic [7:0]  div_q;
   logic        tick;
   rdc_state_e  st_q;
   rdc_op_e     op_q;
   rdc_op_e     new_op;
   logic [2:0]  pbank_q;
   logic        init_q;
   logic [20:0] paddr_q;
   logic [20:0] sw_addr_q;
   logic        pend_q;
   logic        err_q;
   logic        stale_q;
   logic        two_q;
   logic [17:0] mode_q;
   logic [3:0]  gap_q;
   logic [4:0]  quiet_q;
   logic [10:0] loop_cnt_q;
   logic [3:0]  bank_cnt_q [8];
   logic        any_busy;
   logic        go;
   logic        fire;
   logic        done;
   logic        cmd_legal;
   logic [3:0]  rl;
   logic [3:0]  wl;
   logic [1:0]  blc;
   logic        mux;
   logic        loop_rdy;
   logic [20:0] first_addr;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [3:0] cfg_rl(input logic [2:0] c);
      return 4'(`RDC_RL_BASE + `RDC_RL_STEP * c[1:0]);
   endfunction : cfg_rl

   function automatic logic [3:0] beats(input logic [1:0] b);
      return 4'(4'h1 << b);
   endfunction : beats

   function automatic logic [4:0] addr_w(input logic [1:0] b);
      return 5'(`RDC_ADDR_W - ORG - int'(b));
   endfunction : addr_w

   function automatic logic mode_ok(input logic [17:0] m);
      return (m[`RDC_M_CFG] <= `RDC_CFG_MAX)
         && (m[`RDC_M_BL] != `RDC_BL_RSV)
         && !(m[`RDC_M_BL] == `RDC_BL8 && m[`RDC_M_CFG] == `RDC_CFG1)
         && (m[`RDC_M_ZERO] == 8'h00);
   endfunction : mode_ok

   // returns {write_enable_n, refresh_strobe_n}
   function automatic logic [1:0] op_code(input rdc_op_e o);
      case (o)
         OP_MODE:  return 2'h0;
         OP_READ:  return 2'h3;
         OP_WRITE: return 2'h1;
         default:  return 2'h2;
      endcase
   endfunction : op_code

   rdc_axil u_axil (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // ************************************************************
   // device clock divider; tick marks the falling edge
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q     <= 8'h00;
         dev_clk   <= 1'b0;
         dev_clk_n <= 1'b1;
      end else if (div_q == 8'(DIV - 1)) begin
         div_q     <= 8'h00;
         dev_clk   <= ~dev_clk;
         dev_clk_n <= dev_clk;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
   assign tick = (div_q == 8'(DIV - 1)) && dev_clk;

   // ************************************************************
   // decoded mode
   // ************************************************************
   assign rl       = cfg_rl(mode_q[`RDC_M_CFG]);
   assign wl       = rl + 4'h1;
   assign blc      = mode_q[`RDC_M_BL];
   assign mux      = mode_q[`RDC_M_MUX];
   assign loop_rdy = mode_q[`RDC_M_LOOP] && (loop_cnt_q == 11'h0);
   assign new_op   = rdc_op_e'(wr_data[`RDC_F_OP]);
   assign fire     = tick && (st_q == ST_WAIT) && go;
   assign done     = tick && ((st_q == ST_ISSUE && !two_q)
                     || st_q == ST_SECOND);

   always_comb begin
      case (new_op)
         OP_MODE:  cmd_legal = mode_ok(sw_addr_q[`RDC_M_ALL]);
         OP_REF:   cmd_legal = 1'b1;
         default:  cmd_legal = (sw_addr_q >> addr_w(blc)) == 21'h0;
      endcase
   end

   always_comb begin
      any_busy = 1'b0;
      for (int i = 0; i < 8; i++) begin
         any_busy = any_busy || (bank_cnt_q[i] != 4'h0);
      end
   end

   always_comb begin
      go = (gap_q == 4'h0) && (bank_cnt_q[pbank_q] == 4'h0);
      case (op_q)
         OP_MODE: go = (init_q || gap_q == 4'h0) && (quiet_q == 5'h0)
                       && !any_busy;
         OP_READ: go = go && (loop_cnt_q == 11'h0);
         default: ;
      endcase
   end

   always_comb begin
      case (op_q)
         OP_MODE: first_addr = 21'(paddr_q[`RDC_M_LOW]);
         OP_REF:  first_addr = 21'h0;
         default: first_addr = mux ? 21'(paddr_q[`RDC_AX]) : paddr_q;
      endcase
   end

   // ************************************************************
   // software registers
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_addr_q <= 21'h0;
         op_q      <= OP_MODE;
         pbank_q   <= 3'h0;
         init_q    <= 1'b0;
         paddr_q   <= 21'h0;
         pend_q    <= 1'b0;
         err_q     <= 1'b0;
         stale_q   <= 1'b0;
      end else begin
         if (wr_en && wr_addr == `RDC_OFS_ADDR) begin
            sw_addr_q <= wr_data[20:0];
         end
         if (done) begin
            pend_q <= 1'b0;
         end
         if (wr_en && wr_addr == `RDC_OFS_CMD) begin
            if (pend_q || !cmd_legal) begin
               err_q <= 1'b1;
            end else begin
               pend_q  <= 1'b1;
               err_q   <= 1'b0;
               op_q    <= new_op;
               pbank_q <= wr_data[`RDC_F_BANK];
               init_q  <= wr_data[`RDC_F_INIT];
               paddr_q <= sw_addr_q;
            end
         end
         if (fire && op_q == OP_MODE && paddr_q[`RDC_M_BL] != blc) begin
            stale_q <= 1'b1;
         end else if (wr_en && wr_addr == `RDC_OFS_STAT
                      && wr_data[`RDC_S_STALE]) begin
            stale_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // command sequencer and pins
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q             <= ST_IDLE;
         two_q            <= 1'b0;
         chip_select_n    <= 1'b1;
         write_enable_n   <= 1'b1;
         refresh_strobe_n <= 1'b1;
         address          <= 21'h0;
         bank_select      <= 3'h0;
      end else if (tick) begin
         case (st_q)
            ST_IDLE: begin
               if (pend_q) begin
                  st_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (go) begin
                  st_q          <= ST_ISSUE;
                  chip_select_n <= 1'b0;
                  {write_enable_n, refresh_strobe_n} <= op_code(op_q);
                  bank_select   <= (op_q == OP_MODE) ? 3'h0 : pbank_q;
                  address       <= first_addr;
                  two_q         <= mux && (op_q != OP_REF);
               end
            end
            ST_ISSUE: begin
               chip_select_n    <= 1'b1;
               write_enable_n   <= 1'b1;
               refresh_strobe_n <= 1'b1;
               bank_select      <= 3'h0;
               if (two_q && op_q != OP_MODE) begin
                  address <= 21'(paddr_q[`RDC_AY]);
               end else begin
                  address <= 21'h0;
               end
               st_q <= two_q ? ST_SECOND : ST_IDLE;
            end
            ST_SECOND: begin
               address <= 21'h0;
               st_q    <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // ************************************************************
   // mode word and timing counters, all in device clocks
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q     <= `RDC_MODE_RST;
         gap_q      <= 4'h0;
         quiet_q    <= 5'h0;
         loop_cnt_q <= 11'h0;
         for (int i = 0; i < 8; i++) begin
            bank_cnt_q[i] <= 4'h0;
         end
      end else if (tick) begin
         if (gap_q != 4'h0) begin
            gap_q <= gap_q - 4'h1;
         end
         if (quiet_q != 5'h0) begin
            quiet_q <= quiet_q - 5'h1;
         end
         if (loop_cnt_q != 11'h0) begin
            loop_cnt_q <= loop_cnt_q - 11'h1;
         end
         for (int i = 0; i < 8; i++) begin
            if (bank_cnt_q[i] != 4'h0) begin
               bank_cnt_q[i] <= bank_cnt_q[i] - 4'h1;
            end
         end
         if (fire) begin
            case (op_q)
               OP_MODE: begin
                  mode_q <= paddr_q[`RDC_M_ALL];
                  gap_q  <= MSR_CYC - 4'h1;
                  if (!paddr_q[`RDC_M_LOOP]) begin
                     loop_cnt_q <= 11'h0;
                  end else if (!mode_q[`RDC_M_LOOP]) begin
                     loop_cnt_q <= LOOP_CYC;
                  end
               end
               OP_READ, OP_WRITE: begin
                  quiet_q <= {1'b0, wl} + {1'b0, beats(blc)}
                             + {4'h0, mux};
                  bank_cnt_q[pbank_q] <= rl - 4'h1;
               end
               default: bank_cnt_q[pbank_q] <= rl - 4'h1;
            endcase
         end
      end
   end

   // ************************************************************
   // register read mux
   // ************************************************************
   always_comb begin
      case (rd_addr)
         `RDC_OFS_CMD:  rd_data = {26'h0, init_q, pbank_q, op_q};
         `RDC_OFS_ADDR: rd_data = {11'h0, sw_addr_q};
         `RDC_OFS_STAT: rd_data = {11'h0, mode_q[`RDC_M_TERM],
                                   mode_q[`RDC_M_LOOP], mux, blc, rl, wl,
                                   rl, stale_q, loop_rdy, err_q, pend_q};
         `RDC_OFS_MODE: rd_data = {14'h0, mode_q};
         default:       rd_data = 32'h0;
      endcase
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_first;
      $fell(chip_select_n) && two_q && op_q != OP_MODE;
   endsequence
   sequence s_second;
      chip_select_n && st_q == ST_SECOND
      && address == 21'(paddr_q[`RDC_AY]);
   endsequence

   pin_step_a: assert property (
      !$stable(chip_select_n) |-> $past(tick))
      else $error("pins moved off the falling edge");
   code_map_a: assert property (
      $fell(chip_select_n) |-> {write_enable_n, refresh_strobe_n}
                               == op_code(op_q))
      else $error("strobe code does not match command");
   mode_zero_a: assert property (
      !chip_select_n && !write_enable_n && !refresh_strobe_n
      |-> address[`RDC_M_ZERO] == 8'h00)
      else $error("mode set with upper address bits set");
   mode_idle_a: assert property (
      $fell(chip_select_n) && op_q == OP_MODE
      |-> $past(quiet_q) == 5'h0 && !$past(any_busy))
      else $error("mode set while busy");
   recov_gap_a: assert property (
      $fell(chip_select_n) && !(op_q == OP_MODE && init_q)
      |-> $past(gap_q) == 4'h0)
      else $error("command inside mode set recovery");
   loop_wait_a: assert property (
      $fell(chip_select_n) && op_q == OP_READ
      |-> $past(loop_cnt_q) == 11'h0)
      else $error("read before loop settle time");
   row_space_a: assert property (
      $fell(chip_select_n) && op_q != OP_MODE
      |-> $past(bank_cnt_q[pbank_q]) == 4'h0)
      else $error("bank reused inside row cycle");
   lat_pair_a: assert property (
      wl == rl + 4'h1 && rl >= `RDC_RL_BASE)
      else $error("write latency not read latency plus one");
   bl8_cfg_a: assert property (
      !(blc == `RDC_BL8 && mode_q[`RDC_M_CFG] == `RDC_CFG1))
      else $error("burst eight with first configuration");
   addr_width_a: assert property (
      $fell(chip_select_n) && (op_q == OP_READ || op_q == OP_WRITE)
      |-> (address >> addr_w(blc)) == 21'h0)
      else $error("address wider than burst length allows");
   mux_two_a: assert property (
      s_first |-> ##[1:512] s_second)
      else $error("second address part missing");
   idle_pins_a: assert property (
      (st_q == ST_IDLE || st_q == ST_WAIT) |-> chip_select_n)
      else $error("chip select low while idle");
endmodule : rdc_ctrl

// ==== rdc_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module rdc_ctrl_tb_top import rdc_pkg::*;;
   typedef struct {logic [1:0] op; logic [2:0] bk; logic [20:0] ad;} rdc_row_s;
   logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
   logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, s;
   logic awready, wready, bvalid, arready, rvalid, dev_clk, dev_clk_n;
   logic chip_select_n, write_enable_n, refresh_strobe_n;
   logic [1:0] bresp, rresp, r;
   logic [20:0] address;
   logic [2:0] bank_select;
   int n_mismatch = 0, total_checks = 0, ec [4] = '{default: 0};
   rdc_row_s rows [4] = '{'{OP_MODE, 3'h0, 21'h9}, '{OP_READ, 3'h5, 21'hfffff},
      '{OP_WRITE, 3'h2, 21'h12345}, '{OP_REF, 3'h7, 21'h0}};
   always #5 aclk = ~aclk;
   rdc_ctrl #(.LOOP_CYC(11'h8)) i_rdc_ctrl (.aclk, .aresetn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .dev_clk, .dev_clk_n, .chip_select_n, .write_enable_n,
      .refresh_strobe_n, .address, .bank_select);
   rdc_dev_model #(.LOCK(11'h8)) i_rdc_dev_model (.dev_clk, .chip_select_n,
      .write_enable_n,
      .refresh_strobe_n, .address, .bank_select);
   // ****************
   // bus tasks
   // ****************
   task automatic chk(input string nm, input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic conclude;
      if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (awvalid && !awready || wvalid && !wready);
      while (!bvalid) @(posedge aclk);
      r = bresp;
      bready <= 1'h0;
   endtask : axw
   task automatic axr(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      while (!rvalid) @(posedge aclk);
      s = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask : axr
   // command through the registers, then poll until no longer pending
   task automatic run(input logic [1:0] op, input logic [2:0] bk,
                      input logic [20:0] ad, input logic ok);
      int i;
      axw(4'h4, {11'h0, ad});
      axw(4'h0, {26'h0, 1'h0, bk, op});
      chk("bresp", r, 2'h0);
      i = 0;
      do begin
         axr(4'h8);
         i++;
      end while (s[0] === 1'h1 && i < 200);
      chk("pending", s[0], 1'h0);
      chk("rresp", r, 2'h0);
      if (ok) ec[op]++;
      for (i = 0; i < 4; i++) chk("count", i_rdc_dev_model.n_q[i], ec[i]);
      chk("error", s[1], !ok);
   endtask : run
   // ****************
   // tests
   // ****************
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk("cs idle", chip_select_n, 1'h1);
      axr(4'h8);
      chk("lat reset", s[17:4], 14'h0454);
      chk("clk pair", dev_clk_n, !dev_clk);
      foreach (rows[k]) begin
         run(rows[k].op, rows[k].bk, rows[k].ad, 1'h1);
         chk("lat", s[17:4], 14'h1676);
         if (rows[k].op == OP_MODE)
            chk("mode", i_rdc_dev_model.mode_q, rows[k].ad);
         else
            chk("bank", i_rdc_dev_model.bank_q, rows[k].bk);
         if (rows[k].op inside {OP_READ, OP_WRITE})
            chk("addr", i_rdc_dev_model.addr_q, rows[k].ad);
      end
      run(OP_MODE, 3'h0, 21'h212, 1'h1);
      chk("term", s[20:4], 17'h12898);
      chk("stale", s[3], 1'h1);
      axw(4'h8, 32'h8);
      run(OP_MODE, 3'h0, 21'h10, 1'h0);
      chk("stale clr", s[3], 1'h0);
      run(OP_MODE, 3'h0, 21'h412, 1'h0);
      run(OP_READ, 3'h1, 21'h80000, 1'h0);
      run(OP_READ, 3'h1, 21'h7ffff, 1'h1);
      chk("addr bl8", i_rdc_dev_model.addr_q, 21'h7ffff);
      axw(4'hc, 32'h0);
      chk("mode ro", r, 2'h2);
      axr(4'h2);
      chk("rd err", r, 2'h2);
      chk("rd zero", s, 32'h0);
      run(OP_MODE, 3'h0, 21'hb2, 1'h1);
      run(OP_READ, 3'h3, 21'h5a5a5, 1'h1);
      chk("addr mux", i_rdc_dev_model.addr_q, 21'h5a5a5);
      chk("loop rdy", s[2], 1'h1);
      chk("early rd", i_rdc_dev_model.early_q, 8'h0);
      conclude();
   end
   initial begin
      #100000;
      n_mismatch++;
      conclude();
   end
endmodule : rdc_ctrl_tb_top

// ==== rdc_dev_model.sv ====
`timescale 1ns/1ps
module rdc_dev_model import rdc_pkg::*; #(
   parameter logic [10:0] LOCK = 11'h400
) (
   // device pins
   input wire logic        dev_clk,
   input wire logic        chip_select_n,
   input wire logic        write_enable_n,
   input wire logic        refresh_strobe_n,
   input wire logic [20:0] address,
   input wire logic [2:0]  bank_select
);
   // ****************
   // command decode
   // ****************
   logic [1:0]  op;
   logic [17:0] mode_q = 18'h0;
   logic [20:0] addr_q = 21'h0;
   logic [2:0]  bank_q = 3'h0;
   logic [7:0]  n_q [4] = '{default: 8'h0};
   logic [10:0] lock_q  = 11'h0;
   logic [7:0]  early_q = 8'h0;
   logic        two_q   = 1'b0;
   // strobe pair folded into the controller's op code
   assign op = {write_enable_n ^ refresh_strobe_n, write_enable_n};
   always @(posedge dev_clk) begin
      two_q <= 1'b0;
      // second address part of a multiplexed access
      if (two_q) addr_q[20:11] <= address[9:0];
      if (lock_q != 11'h0) lock_q <= lock_q - 11'h1;
      if (!chip_select_n) begin
         n_q[op] <= n_q[op] + 8'h1;
         if (op == OP_MODE) mode_q <= address[17:0];
         else bank_q <= bank_select;
         if (op == OP_MODE && !address[7]) lock_q <= 11'h0;
         else if (op == OP_MODE && !mode_q[7]) lock_q <= LOCK;
         if (op == OP_READ && mode_q[7] && lock_q != 11'h0)
            early_q <= early_q + 8'h1;
         if (op inside {OP_READ, OP_WRITE}) begin
            addr_q <= address;
            two_q  <= mode_q[5];
         end
      end
   end
endmodule : rdc_dev_model

// ==== rdc_map.svh ====
`ifndef RDC_MAP_SVH
`define RDC_MAP_SVH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define RDC_OFS_CMD   4'h0
`define RDC_OFS_ADDR  4'h4
`define RDC_OFS_STAT  4'h8
`define RDC_OFS_MODE  4'hc
// ************************************************************
// register fields
// ************************************************************
`define RDC_F_OP      1:0
`define RDC_F_BANK    4:2
`define RDC_F_INIT    5
`define RDC_S_STALE   3
// ************************************************************
// mode word fields and codes
// ************************************************************
`define RDC_M_CFG     2:0
`define RDC_M_BL      4:3
`define RDC_M_MUX     5
`define RDC_M_LOOP    7
`define RDC_M_TERM    9
`define RDC_M_ZERO    17:10
`define RDC_M_LOW     9:0
`define RDC_M_ALL     17:0
`define RDC_MODE_RST  18'h00000
`define RDC_CFG1      3'h0
`define RDC_CFG_MAX   3'h2
`define RDC_BL8       2'h2
`define RDC_BL_RSV    2'h3
// ************************************************************
// address layout and timing counts
// ************************************************************
`define RDC_ADDR_W    21
`define RDC_AX        10:0
`define RDC_AY        20:11
`define RDC_RL_BASE   4'h4
`define RDC_RL_STEP   4'h2
`define RDC_MSR_CYC   4'h6
`define RDC_LOOP_CYC  11'h400
`define RDC_OKAY      2'h0
`define RDC_SLVERR    2'h2
`endif

// ==== rdc_pkg.sv ====
package rdc_pkg;
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_WAIT   = 4'b0010,
      ST_ISSUE  = 4'b0100,
      ST_SECOND = 4'b1000
   } rdc_state_e;
   typedef enum logic [1:0] {
      OP_MODE  = 2'h0,
      OP_READ  = 2'h1,
      OP_WRITE = 2'h2,
      OP_REF   = 2'h3
   } rdc_op_e;
endpackage : rdc_pkg
